/* File: dspp_regs.svh */
// Named constants of the decoder status parallel port: pin indices, masks,
// header field positions and start-up timing.
// Assumes a 40 MHz system clock and a 32-bit stream header word.
`ifndef DSPP_REGS_SVH
`define DSPP_REGS_SVH

// ----------------------------------------------------------------------
// Parallel line indices
// ----------------------------------------------------------------------
`define DSPP_PIO_W 20
`define DSPP_PIN_MODE 0
`define DSPP_PIN_FORMAT 1
`define DSPP_PIN_LAYER2 2
`define DSPP_PIN_LAYER3 3
`define DSPP_PIN_CLKSEL 4
`define DSPP_PIN_SCALER 8
`define DSPP_PIN_LAYER_LO 12
`define DSPP_PIN_LAYER_HI 13
`define DSPP_PIN_ALT_DATA 14
`define DSPP_PIN_ALT_FRAME 15
`define DSPP_PIN_ALT_CLOCK 16
`define DSPP_PIN_VERSION 17
`define DSPP_PIN_IDEXT 18
`define DSPP_PIN_DEMAND 19
// Lines that carry status in operation
`define DSPP_DRIVE_MASK 20'hE311F
`define DSPP_PIO_ZERO 20'h00000

// ----------------------------------------------------------------------
// Stream header bit positions
// ----------------------------------------------------------------------
`define DSPP_HB_IDEXT 11
`define DSPP_HB_VERSION 12
`define DSPP_HB_LAYER_A 13
`define DSPP_HB_LAYER_B 14
`define DSPP_HB_SF_A 20
`define DSPP_HB_SF_B 21
`define DSPP_HB_EMPH_A 30
`define DSPP_HB_EMPH_B 31
// Layer code {bit13, bit14}
`define DSPP_LAYER2_CODE 2'h2
`define DSPP_LAYER3_CODE 2'h1

// ----------------------------------------------------------------------
// Mirror vector positions
// ----------------------------------------------------------------------
`define DSPP_MIR_W 8
`define DSPP_MIR_IDEXT 0
`define DSPP_MIR_VERSION 1
`define DSPP_MIR_LAYER_A 2
`define DSPP_MIR_LAYER_B 3
`define DSPP_MIR_SF_A 4
`define DSPP_MIR_SF_B 5
`define DSPP_MIR_EMPH_A 6
`define DSPP_MIR_EMPH_B 7
`define DSPP_MIR_RESET 8'h00

// ----------------------------------------------------------------------
// Start-up timing
// ----------------------------------------------------------------------
`define DSPP_CLK_PERIOD_NS 25
`define DSPP_STARTUP_NS 1000
`define DSPP_CNT_W 8
`define DSPP_CNT_ZERO 8'h00

`endif

/* File: dspp_pkg.sv */
// Types shared by the decoder status parallel port.
// Assumes dspp_regs.svh supplies the numeric constants.
package dspp_pkg;

	// Start-up sequence of the port
	typedef enum logic [1:0] {
		DSPP_WAIT = 2'b00,
		DSPP_SAMPLE = 2'b01,
		DSPP_OPERATE = 2'b10
	} dspp_state_type;

endpackage

/* File: dspp_hdr_latch.sv */
// Holding register for the stream header fields mirrored on the port.
// Assumes load is a one-cycle pulse per decoded header, on the local reset.
`timescale 1ns/100ps
`include "dspp_regs.svh"

module dspp_hdr_latch
	import dspp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_local_n,
	input wire logic load,
	input wire logic [31:0] hdr_word,
	output logic [`DSPP_MIR_W-1:0] mirror_ff
);

	// ------------------------------------------------------------------
	// Field capture
	// ------------------------------------------------------------------
	// Loaded only on a new header so the lines hold for the whole frame
	always_ff @(posedge sys_clk or negedge rst_local_n)
	begin
		if (!rst_local_n)
			mirror_ff <= `DSPP_MIR_RESET;
		else if (load)
		begin
			mirror_ff[`DSPP_MIR_IDEXT] <= hdr_word[`DSPP_HB_IDEXT];
			mirror_ff[`DSPP_MIR_VERSION] <= hdr_word[`DSPP_HB_VERSION];
			mirror_ff[`DSPP_MIR_LAYER_A] <= hdr_word[`DSPP_HB_LAYER_A];
			mirror_ff[`DSPP_MIR_LAYER_B] <= hdr_word[`DSPP_HB_LAYER_B];
			mirror_ff[`DSPP_MIR_SF_A] <= hdr_word[`DSPP_HB_SF_A];
			mirror_ff[`DSPP_MIR_SF_B] <= hdr_word[`DSPP_HB_SF_B];
			mirror_ff[`DSPP_MIR_EMPH_A] <= hdr_word[`DSPP_HB_EMPH_A];
			mirror_ff[`DSPP_MIR_EMPH_B] <= hdr_word[`DSPP_HB_EMPH_B];
		end
	end

endmodule

/* File: dspp_port.sv */
// Decoder status parallel port: start-up strap capture, then status
// output on the dual-purpose parallel lines.
// Assumes decoder events arrive as one-cycle pulses on sys_clk and the
// pad ring resolves the line level from pio_out_ff and pio_oe_ff.
`timescale 1ns/100ps
`include "dspp_regs.svh"

// Contract
// - Sample operating mode strap at start-up
// - Sample output format strap at start-up
// - Sample layer 2 enable strap
// - Sample layer 3 enable strap
// - Sample input clock frequency select strap
// - Sample clock output scaler strap
// - Strap sampling ignores handshake inputs
// - Drive status when selected and direction high
// - Demand line high when data needed
// - Mirror sampling-frequency bits on layer straps
// - Mirror emphasis bits on format/mode straps
// - Mirror id extension, version, layer bits
// - Error flag on CRC fail or no stream
// - Error flag lasts exactly one frame; here it is held from the failure to the next frame boundary
// - Sync flag inactive after reset
// - Sync flag set on valid layer 2/3 header
// - Sync flag cleared by ancillary data read
// - Upper three lines usable as serial inputs; here lines 14 to 16 are used
// - Handshake outputs stay inactive, unused
// - Decoder runs only while enable held
// - Ready reports clock, then synthesizer lock
module dspp_port
	import dspp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [`DSPP_PIO_W-1:0] pio_in,
	output logic [`DSPP_PIO_W-1:0] pio_out_ff,
	output logic [`DSPP_PIO_W-1:0] pio_oe_ff,
	input wire logic pio_select_n,
	input wire logic pio_direction_select,
	input wire logic decoder_enable,
	input wire logic input_clock_valid,
	input wire logic synth_locked,
	input wire logic demand_need,
	input wire logic frame_start,
	input wire logic hdr_strobe,
	input wire logic [31:0] hdr_word,
	input wire logic decoder_synced,
	input wire logic crc_error,
	input wire logic no_stream,
	input wire logic ancillary_read,
	input wire logic alt_serial_enable,
	output logic alt_serial_clock_fn_ff,
	output logic alt_serial_frame_fn_ff,
	output logic alt_serial_data_fn_ff,
	output logic cfg_broadcast_mode_ff,
	output logic cfg_format_16bit_ff,
	output logic cfg_layer2_en_ff,
	output logic cfg_layer3_en_ff,
	output logic cfg_clk_alt_freq_ff,
	output logic cfg_clkout_scaler_ff,
	output logic startup_done_ff,
	output logic decoder_run_ff,
	output logic decoder_ready_ff,
	output logic ready_to_read_n_ff,
	output logic ready_to_write_n_ff,
	output logic dma_end_n_ff
);

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	// Least time in ns to whole clock cycles, never below one
	function automatic logic [`DSPP_CNT_W-1:0] ns_to_cycles(input int ns);
		int c;
		c = (ns + `DSPP_CLK_PERIOD_NS - 1) / `DSPP_CLK_PERIOD_NS;
		if (c < 1)
			c = 1;
		return c[`DSPP_CNT_W-1:0];
	endfunction

	// Header carries layer 2 or layer 3
	function automatic logic layer_ok(input logic [31:0] h);
		logic [1:0] code;
		code = {h[`DSPP_HB_LAYER_A], h[`DSPP_HB_LAYER_B]};
		return (code == `DSPP_LAYER2_CODE) || (code == `DSPP_LAYER3_CODE);
	endfunction

	localparam logic [`DSPP_CNT_W-1:0] STARTUP_CYCLES = ns_to_cycles(`DSPP_STARTUP_NS);

	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------
	logic rst_sync1_ff;
	logic rst_sync2_ff;
	logic rst_local_n;

	// Two stages so release never lands close to a clock edge
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_sync1_ff <= 1'b0;
			rst_sync2_ff <= 1'b0;
		end
		else
		begin
			rst_sync1_ff <= 1'b1;
			rst_sync2_ff <= rst_sync1_ff;
		end
	end

	assign rst_local_n = rst_sync2_ff;

	// ------------------------------------------------------------------
	// Start-up sequence
	// ------------------------------------------------------------------
	dspp_state_type state_ff;
	dspp_state_type nxt_state;
	logic [`DSPP_CNT_W-1:0] wait_cnt_ff;

	// Straps need settling time after reset before they are trusted
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			DSPP_WAIT:
				if (wait_cnt_ff == STARTUP_CYCLES)
					nxt_state = DSPP_SAMPLE;
			DSPP_SAMPLE:
				nxt_state = DSPP_OPERATE;
			DSPP_OPERATE:
				nxt_state = DSPP_OPERATE;
			default:
				nxt_state = DSPP_WAIT;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_local_n)
	begin
		if (!rst_local_n)
			state_ff <= DSPP_WAIT;
		else
			state_ff <= nxt_state;
	end

	// Settling counter, stops when DSPP_WAIT ends, one cycle before the straps are taken
	always_ff @(posedge sys_clk or negedge rst_local_n)
	begin
		if (!rst_local_n)
			wait_cnt_ff <= `DSPP_CNT_ZERO;
		else if (state_ff == DSPP_WAIT)
			wait_cnt_ff <= wait_cnt_ff + 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rst_local_n)
	begin
		if (!rst_local_n)
			startup_done_ff <= 1'b0;
		else if (state_ff == DSPP_SAMPLE)
			startup_done_ff <= 1'b1;
	end

	// ------------------------------------------------------------------
	// Strap capture
	// ------------------------------------------------------------------
	// Sampled from the lines alone, select and direction play no part
	always_ff @(posedge sys_clk or negedge rst_local_n)
	begin
		if (!rst_local_n)
		begin
			cfg_broadcast_mode_ff <= 1'b0;
			cfg_format_16bit_ff <= 1'b0;
			cfg_layer2_en_ff <= 1'b0;
			cfg_layer3_en_ff <= 1'b0;
			cfg_clk_alt_freq_ff <= 1'b0;
			cfg_clkout_scaler_ff <= 1'b0;
		end
		else if (state_ff == DSPP_SAMPLE)
		begin
			cfg_broadcast_mode_ff <= pio_in[`DSPP_PIN_MODE];
			cfg_format_16bit_ff <= pio_in[`DSPP_PIN_FORMAT];
			cfg_layer2_en_ff <= pio_in[`DSPP_PIN_LAYER2];
			cfg_layer3_en_ff <= pio_in[`DSPP_PIN_LAYER3];
			cfg_clk_alt_freq_ff <= pio_in[`DSPP_PIN_CLKSEL];
			cfg_clkout_scaler_ff <= pio_in[`DSPP_PIN_SCALER];
		end
	end

	// ------------------------------------------------------------------
	// Header mirror
	// ------------------------------------------------------------------
	logic [`DSPP_MIR_W-1:0] mirror;
	logic operating;

	assign operating = (state_ff == DSPP_OPERATE);

	dspp_hdr_latch u_hdr_latch (
		.sys_clk(sys_clk),
		.rst_local_n(rst_local_n),
		.load(hdr_strobe),
		.hdr_word(hdr_word),
		.mirror_ff(mirror)
	);

	// ------------------------------------------------------------------
	// Frame error and frame sync flags
	// ------------------------------------------------------------------
	logic err_flag_ff;
	logic sync_flag_ff;
	logic err_event;
	logic sync_event;

	assign err_event = operating && (crc_error || no_stream);
	assign sync_event = operating && hdr_strobe && decoder_synced && layer_ok(hdr_word);

	// Held to the next frame boundary; a new failure there re-arms it
	always_ff @(posedge sys_clk or negedge rst_local_n)
	begin
		if (!rst_local_n)
			err_flag_ff <= 1'b0;
		else if (err_event)
			err_flag_ff <= 1'b1;
		else if (frame_start)
			err_flag_ff <= 1'b0;
	end

	// Set beats the ancillary read so a header in that cycle is kept
	always_ff @(posedge sys_clk or negedge rst_local_n)
	begin
		if (!rst_local_n)
			sync_flag_ff <= 1'b0;
		else if (sync_event)
			sync_flag_ff <= 1'b1;
		else if (ancillary_read)
			sync_flag_ff <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Parallel line drive
	// ------------------------------------------------------------------
	logic [`DSPP_PIO_W-1:0] nxt_pio_out;
	logic drive_on;

	assign drive_on = startup_done_ff && !pio_select_n && pio_direction_select;

	always_comb
	begin
		nxt_pio_out = `DSPP_PIO_ZERO;
		nxt_pio_out[`DSPP_PIN_MODE] = mirror[`DSPP_MIR_EMPH_B];
		nxt_pio_out[`DSPP_PIN_FORMAT] = mirror[`DSPP_MIR_EMPH_A];
		nxt_pio_out[`DSPP_PIN_LAYER2] = mirror[`DSPP_MIR_SF_B];
		nxt_pio_out[`DSPP_PIN_LAYER3] = mirror[`DSPP_MIR_SF_A];
		nxt_pio_out[`DSPP_PIN_CLKSEL] = sync_flag_ff;
		nxt_pio_out[`DSPP_PIN_SCALER] = err_flag_ff;
		nxt_pio_out[`DSPP_PIN_LAYER_LO] = mirror[`DSPP_MIR_LAYER_B];
		nxt_pio_out[`DSPP_PIN_LAYER_HI] = mirror[`DSPP_MIR_LAYER_A];
		nxt_pio_out[`DSPP_PIN_VERSION] = mirror[`DSPP_MIR_VERSION];
		nxt_pio_out[`DSPP_PIN_IDEXT] = mirror[`DSPP_MIR_IDEXT];
		nxt_pio_out[`DSPP_PIN_DEMAND] = demand_need;
	end

	always_ff @(posedge sys_clk or negedge rst_local_n)
	begin
		if (!rst_local_n)
			pio_out_ff <= `DSPP_PIO_ZERO;
		else
			pio_out_ff <= nxt_pio_out;
	end

	// Serial input lines are never in the mask, so they stay inputs
	always_ff @(posedge sys_clk or negedge rst_local_n)
	begin
		if (!rst_local_n)
			pio_oe_ff <= `DSPP_PIO_ZERO;
		else if (drive_on)
			pio_oe_ff <= `DSPP_DRIVE_MASK;
		else
			pio_oe_ff <= `DSPP_PIO_ZERO;
	end

	// ------------------------------------------------------------------
	// Alternative serial inputs
	// ------------------------------------------------------------------
	// Registered once; the serial receiver must tolerate one cycle of lag
	always_ff @(posedge sys_clk or negedge rst_local_n)
	begin
		if (!rst_local_n)
		begin
			alt_serial_clock_fn_ff <= 1'b0;
			alt_serial_frame_fn_ff <= 1'b0;
			alt_serial_data_fn_ff <= 1'b0;
		end
		else
		begin
			alt_serial_clock_fn_ff <= alt_serial_enable && pio_in[`DSPP_PIN_ALT_CLOCK];
			alt_serial_frame_fn_ff <= alt_serial_enable && pio_in[`DSPP_PIN_ALT_FRAME];
			alt_serial_data_fn_ff <= alt_serial_enable && pio_in[`DSPP_PIN_ALT_DATA];
		end
	end

	// ------------------------------------------------------------------
	// Decoder enable, ready and unused handshake
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_local_n)
	begin
		if (!rst_local_n)
		begin
			decoder_run_ff <= 1'b0;
			decoder_ready_ff <= 1'b0;
			ready_to_read_n_ff <= 1'b1;
			ready_to_write_n_ff <= 1'b1;
			dma_end_n_ff <= 1'b1;
		end
		else
		begin
			decoder_run_ff <= decoder_enable && startup_done_ff;
			decoder_ready_ff <= decoder_enable ? synth_locked : input_clock_valid;
			ready_to_read_n_ff <= 1'b1;
			ready_to_write_n_ff <= 1'b1;
			dma_end_n_ff <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_local_n);

	sequence seq_err_rise;
		err_event ##1 err_flag_ff;
	endsequence

	sequence seq_frame_end;
		frame_start && !err_event;
	endsequence

	a_strap_mode_take: assert property (state_ff == DSPP_SAMPLE |=>
		cfg_broadcast_mode_ff == $past(pio_in[`DSPP_PIN_MODE]) && startup_done_ff)
		else $error("operating mode strap not captured");
	a_strap_format_hold: assert property (startup_done_ff |=> $stable(cfg_format_16bit_ff))
		else $error("output format changed after start-up");
	a_strap_layer_take: assert property (state_ff == DSPP_SAMPLE |=>
		{cfg_layer3_en_ff, cfg_layer2_en_ff} ==
		$past({pio_in[`DSPP_PIN_LAYER3], pio_in[`DSPP_PIN_LAYER2]}))
		else $error("layer enable straps not captured");
	a_strap_clock_take: assert property (state_ff == DSPP_SAMPLE |=>
		{cfg_clkout_scaler_ff, cfg_clk_alt_freq_ff} ==
		$past({pio_in[`DSPP_PIN_SCALER], pio_in[`DSPP_PIN_CLKSEL]}))
		else $error("clock straps not captured");
	a_no_early_drive: assert property (!startup_done_ff |=> pio_oe_ff == `DSPP_PIO_ZERO)
		else $error("lines driven before start-up end");
	a_drive_gate: assert property (startup_done_ff ##1 startup_done_ff |->
		(pio_oe_ff == `DSPP_DRIVE_MASK) == $past(drive_on))
		else $error("line drive does not follow select and direction");
	a_err_frame: assert property (seq_err_rise |-> err_flag_ff until seq_frame_end)
		else $error("error flag dropped inside its frame");
	a_err_clear: assert property (err_flag_ff ##0 seq_frame_end |=> !err_flag_ff)
		else $error("error flag outlived its frame");
	a_err_line: assert property (err_event |-> ##2 pio_out_ff[`DSPP_PIN_SCALER])
		else $error("error event did not reach the line");
	a_sync_set: assert property (sync_event |=> sync_flag_ff ##1
		pio_out_ff[`DSPP_PIN_CLKSEL])
		else $error("sync flag not raised on valid header");
	a_sync_clear: assert property (ancillary_read && !sync_event |=> !sync_flag_ff)
		else $error("sync flag not cleared by ancillary read");
	a_mirror_hold: assert property (!hdr_strobe |=> $stable(mirror))
		else $error("header mirror changed without a header");
	a_ready_src: assert property (##1 decoder_ready_ff ==
		$past(decoder_enable ? synth_locked : input_clock_valid))
		else $error("ready does not follow clock or lock state");
	a_run_gate: assert property (!decoder_enable |=> !decoder_run_ff)
		else $error("decoder runs without enable");
	a_hs_idle: assert property (ready_to_read_n_ff && ready_to_write_n_ff && dma_end_n_ff)
		else $error("unused handshake output active");

endmodule

/* File: dspp_ctrl_model.sv */
// Behavioural controller that sits on the parallel lines of the status port.
// Assumes the bench sets the lines it drives and whether it wants status.
`timescale 1ns/100ps
`include "dspp_regs.svh"

module dspp_ctrl_model
(
	input wire logic sys_clk,
	input wire logic read_req,
	input wire logic [`DSPP_PIO_W-1:0] ext_val,
	input wire logic [`DSPP_PIO_W-1:0] ext_mask,
	input wire logic [`DSPP_PIO_W-1:0] dev_out,
	input wire logic [`DSPP_PIO_W-1:0] dev_oe,
	output logic [`DSPP_PIO_W-1:0] line_lvl,
	output logic pio_select_n,
	output logic pio_direction_select
);
	// ----------------------------------------
	// Floating lines
	// ----------------------------------------
	// Undriven lines flip every cycle, so a stale level never passes as valid
	logic [`DSPP_PIO_W-1:0] float_ff = 20'hA5A5A;

	always @(posedge sys_clk)
		float_ff <= ~float_ff;

	// ----------------------------------------
	// Line resolution and handshake
	// ----------------------------------------
	// Device drive wins; the controller lets go of any line the device owns
	assign line_lvl = (dev_oe & dev_out) | (~dev_oe & ext_mask & ext_val)
		| (~dev_oe & ~ext_mask & float_ff);
	assign pio_select_n = ~read_req;
	assign pio_direction_select = read_req;
endmodule

/* File: dspp_port_tb.sv */
// Self-checking bench for the decoder status parallel port.
// Assumes dspp_ctrl_model resolves the parallel lines in front of the port.
`timescale 1ns/100ps
`include "dspp_regs.svh"

module dspp_port_tb;
	logic sys_clk = 1'b0;
	logic rst_n, read_req, demand_need, alt_serial_enable, decoder_synced;
	logic decoder_enable, input_clock_valid, synth_locked;
	logic [4:0] ev;
	logic [31:0] hdr_word, hdr, r;
	logic [19:0] ext_val, ext_mask, pio_in, pio_out, pio_oe, strap;
	logic select_n, dir, alt_clk, alt_frm, alt_dat, done, run, ready;
	logic rtr_n, rtw_n, dend_n, sync_exp;
	logic [5:0] cfg;
	int miscompares = 0;
	int checks_done = 0;

	// Event pulses: frame start, header, CRC error, no stream, ancillary read
	wire frame_start = ev[0];
	wire hdr_strobe = ev[1];
	wire crc_error = ev[2];
	wire no_stream = ev[3];
	wire ancillary_read = ev[4];

	always #12.5 sys_clk = ~sys_clk;

	dspp_ctrl_model i_ctrl (.sys_clk(sys_clk), .read_req(read_req), .ext_val(ext_val),
		.ext_mask(ext_mask), .dev_out(pio_out), .dev_oe(pio_oe), .line_lvl(pio_in),
		.pio_select_n(select_n), .pio_direction_select(dir));

	dspp_port i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .pio_in(pio_in),
		.pio_out_ff(pio_out), .pio_oe_ff(pio_oe), .pio_select_n(select_n),
		.pio_direction_select(dir), .decoder_enable(decoder_enable),
		.input_clock_valid(input_clock_valid), .synth_locked(synth_locked),
		.demand_need(demand_need), .frame_start(frame_start), .hdr_strobe(hdr_strobe),
		.hdr_word(hdr_word), .decoder_synced(decoder_synced), .crc_error(crc_error),
		.no_stream(no_stream), .ancillary_read(ancillary_read),
		.alt_serial_enable(alt_serial_enable), .alt_serial_clock_fn_ff(alt_clk),
		.alt_serial_frame_fn_ff(alt_frm), .alt_serial_data_fn_ff(alt_dat),
		.cfg_broadcast_mode_ff(cfg[0]), .cfg_format_16bit_ff(cfg[1]),
		.cfg_layer2_en_ff(cfg[2]), .cfg_layer3_en_ff(cfg[3]),
		.cfg_clk_alt_freq_ff(cfg[4]), .cfg_clkout_scaler_ff(cfg[5]),
		.startup_done_ff(done), .decoder_run_ff(run), .decoder_ready_ff(ready),
		.ready_to_read_n_ff(rtr_n), .ready_to_write_n_ff(rtw_n), .dma_end_n_ff(dend_n));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Header bits as they should appear on the status lines
	function automatic logic [19:0] exp_mirror(input logic [31:0] h);
		logic [19:0] e;
		e = 20'h00000;
		e[0] = h[31];
		e[1] = h[30];
		e[2] = h[21];
		e[3] = h[20];
		e[12] = h[14];
		e[13] = h[13];
		e[17] = h[12];
		e[18] = h[11];
		return e;
	endfunction

	task check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// One-cycle event, then wait until the line copy has landed
	task pulse(input logic [4:0] v);
		@(posedge sys_clk);
		ev <= v;
		@(posedge sys_clk);
		ev <= 5'h00;
		cyc(1);
	endtask

	task finish_test;
		$display("miscompares %0d checks_done %0d", miscompares, checks_done);
		if (miscompares == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	// The tests need well under a thousand cycles
	initial
	begin
		#(25 * 4000);
		miscompares++;
		finish_test;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(56));
		strap = 20'($urandom);
		rst_n = 1'b0;
		read_req = 1'b1;
		ext_val = strap;
		ext_mask = 20'hFFFFF;
		ev = 5'h00;
		hdr_word = 32'h00000000;
		{demand_need, alt_serial_enable, decoder_synced} = 3'h0;
		{decoder_enable, input_clock_valid, synth_locked} = 3'h0;
		sync_exp = 1'b0;
		cyc(12);
		check({29'h0, rtr_n, rtw_n, dend_n}, 32'h7);
		check(32'(pio_oe), 32'h0);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		// Controller selects the port throughout start-up: straps still count
		for (int i = 0; i < 100 && done !== 1'b1; i++)
		begin
			check(32'(pio_oe), 32'h0);
			cyc(1);
		end
		check(32'(done), 32'h1);
		check(32'(cfg), {26'h0, strap[8], strap[4], strap[3:0]});
		@(posedge sys_clk);
		ext_val <= ~strap;
		ext_mask <= 20'h1C000;
		cyc(3);
		check(32'(cfg), {26'h0, strap[8], strap[4], strap[3:0]});
		check(32'(pio_oe), 32'hE311F);
		check({29'h0, rtr_n, rtw_n, dend_n}, 32'h7);
		@(posedge sys_clk);
		read_req <= 1'b0;
		cyc(2);
		check(32'(pio_oe), 32'h0);
		@(posedge sys_clk);
		read_req <= 1'b1;
		// Headers with every layer code, synced and not
		for (int i = 0; i < 8; i++)
		begin
			hdr = $urandom;
			{hdr[13], hdr[14]} = 2'(i);
			@(posedge sys_clk);
			hdr_word <= hdr;
			decoder_synced <= (i != 6);
			if (i != 6 && (hdr[14] ^ hdr[13]))
				sync_exp = 1'b1;
			pulse(5'h02);
			check(32'(pio_out & 20'h6300F), 32'(exp_mirror(hdr)));
			check(32'(pio_out[4]), 32'(sync_exp));
			@(posedge sys_clk);
			hdr_word <= ~hdr;
			if (i[0])
			begin
				pulse(5'h10);
				sync_exp = 1'b0;
				check(32'(pio_out[4]), 32'h0);
			end
			cyc(2);
			check(32'(pio_out & 20'h6300F), 32'(exp_mirror(hdr)));
		end
		// Error flag from either cause lasts until the next frame boundary
		for (int k = 0; k < 2; k++)
		begin
			pulse(k == 0 ? 5'h04 : 5'h08);
			check(32'(pio_out[8]), 32'h1);
			cyc(6);
			check(32'(pio_out[8]), 32'h1);
			pulse(5'h01);
			check(32'(pio_out[8]), 32'h0);
		end
		// Random demand, alternate serial lines, enable and ready
		// Each serial level holds 1 us, so the alternate source runs near 500 kHz
		for (int j = 0; j < 12; j++)
		begin
			r = $urandom;
			@(posedge sys_clk);
			demand_need <= r[0];
			alt_serial_enable <= r[1];
			ext_val[16:14] <= r[4:2];
			decoder_enable <= r[5];
			input_clock_valid <= r[6];
			synth_locked <= r[7];
			cyc(40);
			check(32'(pio_out[19]), 32'(r[0]));
			check(32'({alt_clk, alt_frm, alt_dat}), 32'(r[4:2] & {3{r[1]}}));
			check(32'(run), 32'(r[5]));
			check(32'(ready), 32'(r[5] ? r[7] : r[6]));
		end
		finish_test;
	end
endmodule
